// [common/lfp_params.svh]
/*
 * Offsets, field positions, reset values and timing figures of the
 * display output block. Definitions only; included by the rtl, the checker and the bench.
 */
`ifndef LFP_PARAMS_SVH
`define LFP_PARAMS_SVH

// register byte offsets
`define LFP_OFS_CTRL     13'h1100
`define LFP_OFS_FG       13'h1160
`define LFP_OFS_BG       13'h1164
`define LFP_OFS_THIRD    13'h1168
`define LFP_OFS_GAMMA    13'h1200
`define LFP_OFS_GAMMA_HI 13'h125C
`define LFP_OFS_HTIM     13'h1110
`define LFP_OFS_VTIM     13'h1120
`define LFP_OFS_STATUS   13'h1130
`define LFP_OFS_PDW      13'h1140
`define LFP_OFS_PDH      13'h1144
`define LFP_OFS_PDPTR    13'h1148
`define LFP_OFS_PDDATA   13'h114C

// control register bits
`define LFP_CTRL_EN      0
`define LFP_CTRL_PART    1
`define LFP_CTRL_BYP     2
`define LFP_CTRL_DITH    3
`define LFP_CTRL_OSD     4
`define LFP_CTRL_THIRD   6

// reset values
`define LFP_RST_CTRL     16'h0000
`define LFP_RST_COLOUR   16'h0000
`define LFP_RST_HACT     10'd640
`define LFP_RST_HFP      10'd16
`define LFP_RST_HSYNC    10'd96
`define LFP_RST_HBP      10'd48
`define LFP_RST_VACT     10'd480
`define LFP_RST_VFP      10'd10
`define LFP_RST_VSYNC    10'd2
`define LFP_RST_VBP      10'd33
`define LFP_RST_PDW      9'd128
`define LFP_RST_PDH      9'd64

// geometry limits
`define LFP_HMAX         10'd640
`define LFP_VMAX         10'd480
`define LFP_PD_DEPTH     8192
`define LFP_GAMMA_N      24

`endif

// [common/lfp_pkg.sv]
/*
 * Types of the display output block.
 * Assumes lfp_params.svh is on the include path.
 */
package lfp_pkg;

    // one timing phase of a line or a frame
    typedef enum logic [1:0] {PH_ACT, PH_FP, PH_SYNC, PH_BP} lfp_phase_e;

    // full-depth source pixel
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } lfp_rgb_s;

    // panel pin group
    typedef struct packed {
        logic        hs;
        logic        vs;
        logic        de;
        logic [17:0] data;
    } lfp_panel_s;

endpackage

// [rtl/lfp_display.sv]
/*
 * Display output: timing, flipping, overlay, dither, gamma, partial memory, bypass.
 * Assumes a fetcher answering pix_req in the next cycle and a synchronous register port.
 */
`timescale 1ns/1ps
`include "lfp_params.svh"

// Notes on behaviour
// - when reducing 8-bit colour to 6-bit, dither the dropped bits
// - overlay plane of two-bit codes, up to the full screen, over any content
// - code 00 gives the programmed background colour
// - code 10 gives the programmed foreground colour
// - code 01 passes the source, or the third colour when control bit 6 set
// - code 11 gives the bitwise inverse of the source
// - two frame buffers: one scanned out, the other for drawing
// - drawing engine signals a finished frame by a flip request
// - buffers swap only when the next vertical retrace begins
// - software-programmable gamma table over a contiguous register range
// - full mode fetches frame-buffer pixels from memory every refresh
// - partial mode refreshes from an internal 8192 two-bit memory only
// - partial window any width and height fitting the memory; the code holds each in 9 bits, so at most 511
// - partial pixels use the same four-code colour mapping as overlay
// - bypass links host pins straight to panel pins
// - in bypass all internal clocks may stop; only pin paths work
// - active area up to 640 by 480
// - active, porches and retrace lengths programmable; set retrace start
module lfp_display #(
    parameter int PD_DEPTH = `LFP_PD_DEPTH
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [12:0]       reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    // frame fetch and drawing engine
    input  wire logic              flip_req,
    output logic                   pix_req,
    output logic                   disp_buf,
    input  wire lfp_pkg::lfp_rgb_s src_pixel,
    input  wire logic [1:0]        src_osd,
    // host bypass pins
    input  wire lfp_pkg::lfp_panel_s host_pins,
    output logic                   clk_stop_ok,
    // panel pins
    output lfp_pkg::lfp_panel_s    panel
);
    import lfp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register storage

    logic [15:0]      ctrl_r;
    logic [15:0]      fg_r;
    logic [15:0]      bg_r;
    logic [15:0]      third_r;
    logic [15:0]      gamma_r [`LFP_GAMMA_N];
    logic [9:0]       hlen_r  [4];
    logic [9:0]       vlen_r  [4];
    logic [8:0]       pdw_r;
    logic [8:0]       pdh_r;
    logic [12:0]      pd_wptr_r;
    logic [1:0]       pd_mem  [PD_DEPTH];
    logic [15:0]      rdata_r;
    logic             pend_r;
    logic             disp_buf_r;
    lfp_phase_e       hph_r;
    lfp_phase_e       vph_r;
    logic [9:0]       hcnt_r;
    logic [9:0]       vcnt_r;
    logic             tim_rd;
    logic             wr_gamma;
    logic [4:0]       gidx;
    logic             en;
    logic             part;

    assign en       = ctrl_r[`LFP_CTRL_EN];
    assign part     = ctrl_r[`LFP_CTRL_PART];
    assign wr_gamma = reg_addr >= `LFP_OFS_GAMMA && reg_addr <= `LFP_OFS_GAMMA_HI;
    assign gidx     = 5'((reg_addr - `LFP_OFS_GAMMA) >> 2);
    assign tim_rd   = reg_addr >= `LFP_OFS_HTIM && reg_addr <= `LFP_OFS_VTIM + 13'h000C && reg_addr[1:0] == 2'b00;

    // control and colour registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= `LFP_RST_CTRL;
            fg_r    <= `LFP_RST_COLOUR;
            bg_r    <= `LFP_RST_COLOUR;
            third_r <= `LFP_RST_COLOUR;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `LFP_OFS_CTRL:  ctrl_r  <= reg_wdata;
                `LFP_OFS_FG:    fg_r    <= reg_wdata;
                `LFP_OFS_BG:    bg_r    <= reg_wdata;
                `LFP_OFS_THIRD: third_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // gamma table, one word per entry
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gamma_r <= '{default: 16'h0000};
        end else if (reg_wr && wr_gamma) begin
            gamma_r[gidx] <= reg_wdata;
        end
    end

    // timing lengths; active lengths clamped to the panel limit
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hlen_r[0] <= `LFP_RST_HACT;
            hlen_r[1] <= `LFP_RST_HFP;
            hlen_r[2] <= `LFP_RST_HSYNC;
            hlen_r[3] <= `LFP_RST_HBP;
            vlen_r[0] <= `LFP_RST_VACT;
            vlen_r[1] <= `LFP_RST_VFP;
            vlen_r[2] <= `LFP_RST_VSYNC;
            vlen_r[3] <= `LFP_RST_VBP;
        end else if (reg_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (reg_addr == `LFP_OFS_HTIM + 13'(4 * i)) begin
                    hlen_r[i] <= (i == 0 && reg_wdata[9:0] > `LFP_HMAX) ? `LFP_HMAX
                                          : reg_wdata[9:0];
                end
                if (reg_addr == `LFP_OFS_VTIM + 13'(4 * i)) begin
                    vlen_r[i] <= (i == 0 && reg_wdata[9:0] > `LFP_VMAX) ? `LFP_VMAX
                                          : reg_wdata[9:0];
                end
            end
        end
    end

    // partial window size and write pointer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pdw_r     <= `LFP_RST_PDW;
            pdh_r     <= `LFP_RST_PDH;
            pd_wptr_r <= 13'h0000;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `LFP_OFS_PDW:    pdw_r     <= reg_wdata[8:0];
                `LFP_OFS_PDH:    pdh_r     <= reg_wdata[8:0];
                `LFP_OFS_PDPTR:  pd_wptr_r <= reg_wdata[12:0];
                `LFP_OFS_PDDATA: pd_wptr_r <= pd_wptr_r + 13'h0008;
                default: ;
            endcase
        end
    end

    // internal partial memory: eight pixels per data write, no reset needed
    always_ff @(posedge core_clk) begin
        if (reg_wr && reg_addr == `LFP_OFS_PDDATA) begin
            for (int i = 0; i < 8; i++) begin
                pd_mem[13'(pd_wptr_r + 13'(i))] <= reg_wdata[2*i +: 2];
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else if (!reg_rd) begin
            rdata_r <= 16'h0000;
        end else if (wr_gamma) begin
            rdata_r <= gamma_r[gidx];
        end else if (tim_rd) begin
            rdata_r <= {6'h00, reg_addr[5] ? vlen_r[reg_addr[3:2]] : hlen_r[reg_addr[3:2]]};
        end else begin
            unique case (reg_addr)
                `LFP_OFS_CTRL:   rdata_r <= ctrl_r;
                `LFP_OFS_FG:     rdata_r <= fg_r;
                `LFP_OFS_BG:     rdata_r <= bg_r;
                `LFP_OFS_THIRD:  rdata_r <= third_r;
                `LFP_OFS_STATUS: rdata_r <= {10'h000, pend_r, disp_buf_r, vph_r, hph_r};
                `LFP_OFS_PDW:    rdata_r <= {7'h00, pdw_r};
                `LFP_OFS_PDH:    rdata_r <= {7'h00, pdh_r};
                `LFP_OFS_PDPTR:  rdata_r <= {3'h0, pd_wptr_r};
                default:         rdata_r <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timing generator

    logic h_last;
    logic v_last;
    logic line_end;
    logic retrace_go;
    logic de0;
    // a zero length behaves as one cycle
    assign h_last     = hcnt_r + 10'd1 >= hlen_r[hph_r];
    assign v_last     = vcnt_r + 10'd1 >= vlen_r[vph_r];
    assign line_end   = h_last && hph_r == PH_BP;
    assign retrace_go = en && line_end && v_last && vph_r == PH_FP;
    assign de0        = en && hph_r == PH_ACT && vph_r == PH_ACT;

    // horizontal counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hcnt_r <= 10'd0;
            hph_r  <= PH_ACT;
        end else if (!en) begin
            hcnt_r <= 10'd0;
            hph_r  <= PH_ACT;
        end else if (h_last) begin
            hcnt_r <= 10'd0;
            hph_r  <= lfp_phase_e'(hph_r + 2'd1); // back porch wraps to active
        end else begin
            hcnt_r <= hcnt_r + 10'd1;
        end
    end

    // vertical counter advances once per line
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vcnt_r <= 10'd0;
            vph_r  <= PH_ACT;
        end else if (!en) begin
            vcnt_r <= 10'd0;
            vph_r  <= PH_ACT;
        end else if (line_end) begin
            if (v_last) begin
                vcnt_r <= 10'd0;
                vph_r  <= lfp_phase_e'(vph_r + 2'd1);
            end else begin
                vcnt_r <= vcnt_r + 10'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flipping: request waits for retrace, a new request wins over the clear

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r     <= 1'b0;
            disp_buf_r <= 1'b0;
        end else begin
            pend_r <= flip_req || (pend_r && !retrace_go);
            if (pend_r && retrace_go) begin
                disp_buf_r <= !disp_buf_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // partial memory read-out, address runs through the window

    logic [12:0] pd_rptr_r;
    logic        in_win;

    assign in_win = part && {1'b0, hcnt_r} < {1'b0, pdw_r} && {1'b0, vcnt_r} < {1'b0, pdh_r};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_rptr_r <= 13'h0000;
        end else if (retrace_go) begin
            pd_rptr_r <= 13'h0000;
        end else if (de0 && in_win) begin
            pd_rptr_r <= pd_rptr_r + 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // stage 1: fetch request out, sync signals and partial code held

    logic       pix_req_r;
    logic       de1_r;
    logic       hs1_r;
    logic       vs1_r;
    logic [1:0] pd_code1_r;
    logic [1:0] bay1_r;
    logic [6:0] st2_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_req_r  <= 1'b0;
            de1_r      <= 1'b0;
            hs1_r      <= 1'b0;
            vs1_r      <= 1'b0;
            pd_code1_r <= 2'b00;
            bay1_r     <= 2'b00;
            st2_r      <= 7'h00;
        end else begin
            pix_req_r  <= de0 && !part;
            de1_r      <= de0;
            hs1_r      <= en && hph_r == PH_SYNC;
            vs1_r      <= en && vph_r == PH_SYNC;
            pd_code1_r <= in_win ? pd_mem[pd_rptr_r] : 2'b00;
            bay1_r     <= {hcnt_r[0], vcnt_r[0]};
            st2_r      <= {de1_r, hs1_r, vs1_r, pd_code1_r, bay1_r}; // waits for the fetched pixel
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // colour path: overlay mapping, dither, gamma

    function automatic lfp_rgb_s expand(input logic [15:0] c);
        expand = '{r: {c[15:11], c[15:13]}, g: {c[10:5], c[10:9]}, b: {c[4:0], c[4:2]}};
    endfunction

    // one mapping serves both the overlay plane and partial memory
    function automatic lfp_rgb_s osd_map(input logic [1:0] code, input lfp_rgb_s s,
                                         input logic [15:0] bg, input logic [15:0] fg,
                                         input logic [15:0] th, input logic use_th);
        unique case (code)
            2'b00: osd_map = expand(bg);
            2'b10: osd_map = expand(fg);
            2'b01: osd_map = use_th ? expand(th) : s;
            2'b11: osd_map = ~s;
        endcase
    endfunction

    // ordered 2x2 threshold spreads the two dropped bits over neighbours
    function automatic logic [5:0] dith(input logic [7:0] v, input logic [1:0] pos, input logic on);
        logic [8:0] sum;
        logic [1:0] thr;
        thr = {pos[1] ^ pos[0], pos[0]};
        sum = {1'b0, v} + (on ? {7'h00, thr} : 9'h000);
        dith = sum[8] ? 6'h3F : sum[7:2];
    endfunction

    // piecewise-linear curve: base in bits 5:0, slope in bits 11:8
    function automatic logic [5:0] gam(input logic [15:0] e, input logic [2:0] lo);
        logic [6:0] sum;
        logic [6:0] step;
        step = 7'(({3'b000, e[11:8]} * {4'h0, lo}) >> 2);
        sum  = {1'b0, e[5:0]} + step;
        gam  = sum[6] ? 6'h3F : sum[5:0];
    endfunction

    lfp_rgb_s   src_sel;
    lfp_rgb_s   mixed;
    logic [1:0] code;
    logic [5:0] r6;
    logic [5:0] g6;
    logic [5:0] b6;
    logic [5:0] rg;
    logic [5:0] gg;
    logic [5:0] bg6;

    // partial mode has no fetched source: black underneath
    always_comb begin
        src_sel = part ? '0 : src_pixel;
        if (part) begin
            code = st2_r[3:2];
        end else if (ctrl_r[`LFP_CTRL_OSD]) begin
            code = src_osd;
        end else begin
            code = 2'b01;
        end
        mixed = osd_map(code, src_sel, bg_r, fg_r, third_r, ctrl_r[`LFP_CTRL_THIRD]);
        r6    = dith(mixed.r, st2_r[1:0], ctrl_r[`LFP_CTRL_DITH]);
        g6    = dith(mixed.g, st2_r[1:0], ctrl_r[`LFP_CTRL_DITH]);
        b6    = dith(mixed.b, st2_r[1:0], ctrl_r[`LFP_CTRL_DITH]);
        rg    = gam(gamma_r[{2'b00, r6[5:3]}], r6[2:0]);
        gg    = gam(gamma_r[5'd8 + {2'b00, g6[5:3]}], g6[2:0]);
        bg6   = gam(gamma_r[5'd16 + {2'b00, b6[5:3]}], b6[2:0]);
    end

    ////////////////////////////////////////////////////////////////////////
    // stage 2: panel pins

    lfp_panel_s panel_r;
    logic       byp_r;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            panel_r <= '0;
            byp_r   <= 1'b0;
        end else begin
            panel_r.hs   <= st2_r[5];
            panel_r.vs   <= st2_r[4];
            panel_r.de   <= st2_r[6];
            panel_r.data <= st2_r[6] ? {rg, gg, bg6} : 18'h0_0000;
            byp_r        <= ctrl_r[`LFP_CTRL_BYP];
        end
    end

    // bypass is a pure wire path so it works with this clock stopped
    assign panel       = byp_r ? host_pins : panel_r;
    assign clk_stop_ok = byp_r;
    assign pix_req     = pix_req_r;
    assign disp_buf    = disp_buf_r;
    assign reg_rdata   = rdata_r;

endmodule

// [verification/lfp_display_checker.sv]
/*
 * Port checker of the display block; bound from the bench top.
 */
`timescale 1ns/1ps
`include "lfp_params.svh"
module lfp_display_checker (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst_n,
    // register port
    input wire logic [12:0]       reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    // fetch and flip
    input wire logic              flip_req,
    input wire logic              pix_req,
    input wire logic              disp_buf,
    input wire lfp_pkg::lfp_rgb_s src_pixel,
    input wire logic [1:0]        src_osd,
    // pins
    input wire lfp_pkg::lfp_panel_s host_pins,
    input wire logic              clk_stop_ok,
    input wire lfp_pkg::lfp_panel_s panel
);
    import lfp_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] ctrl_r;
    // control shadow, so mode checks need no internals
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            ctrl_r <= 16'h0000;
        else if (reg_wr && reg_addr == `LFP_OFS_CTRL)
            ctrl_r <= reg_wdata;
    end
    wire fetch_ok = ctrl_r[0] && !ctrl_r[1];
    ////////////////////////////////////////////////////////////////////////
    property p_swap_at_retrace;
        $changed(disp_buf) && !clk_stop_ok |-> ##[0:3] $rose(panel.vs);
    endproperty
    a_swap_at_retrace: assert property (p_swap_at_retrace) else $error("buffer swap off retrace");
    property p_one_swap;
        $changed(disp_buf) |=> $stable(disp_buf) [*8];
    endproperty
    a_one_swap: assert property (p_one_swap) else $error("double buffer swap");
    property p_no_fetch;
        pix_req |-> $past(fetch_ok);
    endproperty
    a_no_fetch: assert property (p_no_fetch) else $error("fetch while partial or off");
    property p_fetch_to_de;
        pix_req && !clk_stop_ok |-> ##2 (panel.de || clk_stop_ok);
    endproperty
    a_fetch_to_de: assert property (p_fetch_to_de) else $error("fetched pixel not shown");
    property p_de_from_fetch;
        $rose(panel.de) && fetch_ok && $past(fetch_ok, 3) && !clk_stop_ok |-> $past(pix_req, 2);
    endproperty
    a_de_from_fetch: assert property (p_de_from_fetch) else $error("pixel shown unfetched");
    property p_bypass_pins;
        clk_stop_ok |-> panel == host_pins;
    endproperty
    a_bypass_pins: assert property (p_bypass_pins) else $error("bypass pins differ");
    property p_clk_stop;
        $rose(ctrl_r[2]) |-> ##[0:1] clk_stop_ok;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("clock stop not granted");
    property p_sync_no_de;
        panel.de && !clk_stop_ok |-> !panel.hs && !panel.vs;
    endproperty
    a_sync_no_de: assert property (p_sync_no_de) else $error("sync during active");
    property p_blank_zero;
        !panel.de && !clk_stop_ok |-> panel.data == 18'h0_0000;
    endproperty
    a_blank_zero: assert property (p_blank_zero) else $error("data outside active");
    property p_rdata_pulse;
        reg_rdata != 16'h0000 |-> $past(reg_rd);
    endproperty
    a_rdata_pulse: assert property (p_rdata_pulse) else $error("stray read data");
    property p_ctrl_read;
        reg_rd && reg_addr == `LFP_OFS_CTRL |=> reg_rdata == ctrl_r;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
    c_swap: cover property ($changed(disp_buf));
    c_bypass: cover property ($rose(clk_stop_ok));
    c_fetch: cover property ($rose(pix_req));
endmodule

// [verification/lfp_fetch_model.sv]
/*
 * Fetch model: answers a pixel request in the next cycle with bench-chosen values.
 */
`timescale 1ns/1ps
module lfp_fetch_model (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // request and chosen answer
    input  wire logic              pix_req,
    input  wire lfp_pkg::lfp_rgb_s pix_val,
    input  wire logic [1:0]        osd_val,
    // answer
    output lfp_pkg::lfp_rgb_s      src_pixel,
    output logic [1:0]             src_osd
);
    import lfp_pkg::*;
    // between answers the bus toggles, so a late or early sample shows garbage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_pixel <= '0;
            src_osd   <= 2'b00;
        end else if (pix_req) begin
            src_pixel <= pix_val;
            src_osd   <= osd_val;
        end else begin
            src_pixel <= ~src_pixel;
            src_osd   <= ~src_osd;
        end
    end
endmodule

// [verification/lcd_overlay_flip_partial_display_tb.sv]
/*
 * Bench of the display block; small timing gives a 98-clock frame.
 */
`timescale 1ns/1ps
`include "lfp_params.svh"
module lcd_overlay_flip_partial_display_tb;
    import lfp_pkg::*;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [1:0]  osd;
        lfp_rgb_s    src;
        logic [17:0] exp;
    } lfp_row_s;
    localparam logic [15:0] FG  = 16'hF800;
    localparam logic [15:0] BG  = 16'h001F;
    localparam logic [15:0] TH  = 16'h07E0;
    localparam lfp_rgb_s    SRC = 24'h12_80F0;
    localparam logic [15:0] TIM [8] = '{16'h0008, 16'h0002, 16'h0002, 16'h0002,
                                        16'h0004, 16'h0001, 16'h0001, 16'h0001};
    logic        core_clk, rst_n, reg_wr, reg_rd, flip_req;
    logic [12:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic        pix_req, disp_buf, clk_stop_ok, b0, nb;
    lfp_rgb_s    src_pixel, pix_val;
    logic [1:0]  src_osd, osd_val;
    lfp_panel_s  host_pins, panel;
    lfp_row_s    rows [6];
    int          n_mismatch = 0, num_checks = 0, hi = 0, lo = 0;
    lfp_display DUT (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .flip_req, .pix_req, .disp_buf, .src_pixel, .src_osd, .host_pins, .clk_stop_ok, .panel);
    lfp_fetch_model u_fetch (.core_clk, .rst_n, .pix_req, .pix_val, .osd_val, .src_pixel, .src_osd);
    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // table loaded as out = in + 1, saturating
    function automatic logic [5:0] gm(input logic [5:0] v);
        return (v == 6'h3F) ? v : v + 6'h01;
    endfunction
    function automatic logic [17:0] px(input logic [5:0] r, g, b);
        return {gm(r), gm(g), gm(b)};
    endfunction
    function automatic logic [17:0] c565(input logic [15:0] c);
        return px({c[15:11], c[15]}, c[10:5], {c[4:0], c[4]});
    endfunction
    function automatic logic [17:0] s6(input lfp_rgb_s p);
        return px(p.r[7:2], p.g[7:2], p.b[7:2]);
    endfunction
    task automatic chk(input logic [17:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [12:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(18'(reg_rdata), 18'(e));
    endtask
    // rising edge of vs (v=1) or de (v=0), bounded
    task automatic wait_rise(input bit v);
        int i;
        for (i = 0; i < 600 && (v ? panel.vs : panel.de) !== 1'b0; i++) @(posedge core_clk) #1;
        for (; i < 600 && (v ? panel.vs : panel.de) !== 1'b1; i++) @(posedge core_clk) #1;
        if (i >= 600) begin
            n_mismatch++;
            summarize();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n     = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        flip_req  = 1'b0;
        pix_val   = '0;
        osd_val   = 2'b00;
        host_pins = '0;
        rows[0] = '{16'h0011, 2'b00, SRC, c565(BG)};
        rows[1] = '{16'h0011, 2'b10, SRC, c565(FG)};
        rows[2] = '{16'h0011, 2'b01, SRC, s6(SRC)};
        rows[3] = '{16'h0051, 2'b01, SRC, c565(TH)};
        rows[4] = '{16'h0011, 2'b11, SRC, s6(~SRC)};
        rows[5] = '{16'h0001, 2'b11, SRC, s6(SRC)};
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`LFP_OFS_CTRL, 16'h0000);
        rd(`LFP_OFS_HTIM, 16'h0280);
        rd(`LFP_OFS_FG, 16'h0000);
        rd(13'h1004, 16'h0000);
        rd(`LFP_OFS_PDDATA, 16'h0000);
        for (int k = 0; k < 8; k++) wr(`LFP_OFS_HTIM + 13'(4 * k), TIM[k]);
        wr(`LFP_OFS_FG, FG);
        wr(`LFP_OFS_BG, BG);
        wr(`LFP_OFS_THIRD, TH);
        rd(`LFP_OFS_THIRD, TH);
        // unloaded table gives black
        wr(`LFP_OFS_CTRL, 16'h0001);
        pix_val <= SRC;
        wait_rise(1'b1);
        wait_rise(1'b0);
        chk(panel.data, 18'h0_0000);
        for (int k = 0; k < 24; k++) wr(`LFP_OFS_GAMMA + 13'(4 * k), 16'h0401 + 16'(8 * (k % 8)));
        rd(`LFP_OFS_GAMMA_HI, 16'h0439);
        // overlay operations, one row each
        foreach (rows[k]) begin
            wr(`LFP_OFS_CTRL, rows[k].ctrl);
            pix_val <= rows[k].src;
            osd_val <= rows[k].osd;
            wait_rise(1'b1);
            wait_rise(1'b0);
            chk(panel.data, rows[k].exp);
        end
        // dither: low bits 11 round up on three of four 2x2 positions
        wr(`LFP_OFS_CTRL, 16'h0009);
        pix_val <= 24'h43_4343;
        wait_rise(1'b1);
        wait_rise(1'b1);
        repeat (98) begin
            @(posedge core_clk);
            #1;
            hi += int'(panel.de === 1'b1 && panel.data === px(6'h11, 6'h11, 6'h11));
            lo += int'(panel.de === 1'b1 && panel.data === px(6'h10, 6'h10, 6'h10));
        end
        chk(18'(hi), 18'h0_0018);
        chk(18'(lo), 18'h0_0008);
        // two requests in one frame give exactly one swap at retrace
        wr(`LFP_OFS_CTRL, 16'h0001);
        wait_rise(1'b1);
        b0 = disp_buf;
        nb = ~b0;
        for (int k = 0; k < 2; k++) begin
            repeat (k ? 20 : 5) @(posedge core_clk);
            flip_req <= 1'b1;
            @(posedge core_clk);
            flip_req <= 1'b0;
        end
        #1;
        chk(18'(disp_buf), 18'(b0));
        for (int m = 0; m < 2; m++) begin
            wait_rise(1'b1);
            repeat (3) @(posedge core_clk);
            #1;
            chk(18'(disp_buf), 18'(nb));
        end
        // partial window from internal memory, codes 10 then 11
        wr(`LFP_OFS_PDW, 16'h0008);
        wr(`LFP_OFS_PDH, 16'h0004);
        for (int m = 0; m < 2; m++) begin
            wr(`LFP_OFS_PDPTR, 16'h0000);
            repeat (4) wr(`LFP_OFS_PDDATA, m ? 16'hFFFF : 16'hAAAA);
            wr(`LFP_OFS_CTRL, 16'h0003);
            wait_rise(1'b1);
            wait_rise(1'b0);
            chk(panel.data, m ? px(6'h3F, 6'h3F, 6'h3F) : c565(FG));
        end
        // bypass: pins follow the host even between clock edges
        wr(`LFP_OFS_CTRL, 16'h0004);
        host_pins <= 21'h15_5AA5;
        repeat (3) @(posedge core_clk);
        #1;
        chk(18'(clk_stop_ok), 18'h0_0001);
        chk(panel.data, 18'h1_5AA5);
        #5 host_pins.data = 18'h2_A55A;
        #1 chk(panel.data, 18'h2_A55A);
        summarize();
    end
endmodule
bind lfp_display lfp_display_checker u_chk (.core_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flip_req, .pix_req, .disp_buf, .src_pixel, .src_osd,
    .host_pins, .clk_stop_ok, .panel);
